// >>> verilog/cfx_defs.vh
// constants shared by the cascadable clocked fifo design files
`ifndef CFX_DEFS_VH
`define CFX_DEFS_VH
// storage geometry (largest variant; 9 for 512 deep, 11 for 2048 deep)
`define CFX_AW 12
`define CFX_PW 13
`define CFX_DW 9
`define CFX_DEPTH 13'h1000
`define CFX_HALF 13'h0800
`define CFX_ZERO 13'h0000
// programming register layout and default
`define CFX_CFG_DEF 9'h010
`define CFX_CFG_PEN 8
`define CFX_CFG_PCHK 7
`define CFX_THR_MSB 6
`define CFX_THR_W 7
// register map, byte addresses
`define CFX_ADDR_W 12
`define CFX_A_CTRL 12'h000
`define CFX_A_PROG 12'h004
`define CFX_A_STAT 12'h008
`define CFX_CTRL_CASC 0
`define CFX_ST_CNT_LSB 16
// chain token pulse lengths: write token low 1 cycle, read token 2
`define CFX_TX_IDLE 2'h0
`define CFX_TX_WR 2'h2
`define CFX_TX_RD 2'h3
`define CFX_TX_LOW 2'h2
`define CFX_XI_WR 2'h1
`define CFX_XI_MAX 2'h3
`endif

// >>> verilog/cfx_gray_sync.v
// two-stage synchroniser for a gray-coded pointer
`timescale 1ns/1ps
`include "cfx_defs.vh"
module cfx_gray_sync (
  input wire clk, // system clock
  input wire arst_n, // asynchronous reset, active low
  input wire ce, // clock enable
  input wire [`CFX_PW-1:0] din, // gray pointer from the other side
  output reg [`CFX_PW-1:0] dout // synchronised gray pointer
);
  reg [`CFX_PW-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= `CFX_ZERO;
      dout <= `CFX_ZERO;
    end else if (ce) begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// >>> verilog/cfx_ram.v
// fifo word storage, one write port and one asynchronous read port
`timescale 1ns/1ps
`include "cfx_defs.vh"
module cfx_ram (
  input wire clk, // system clock
  input wire ce, // clock enable
  input wire we, // write strobe
  input wire [`CFX_AW-1:0] waddr, // write location
  input wire [`CFX_DW-1:0] wdata, // word to store
  input wire [`CFX_AW-1:0] raddr, // read location
  output wire [`CFX_DW-1:0] rdata // word at read location
);
  reg [`CFX_DW-1:0] mem [0:(1<<`CFX_AW)-1];

  // array has no reset: emptiness is tracked by the pointers
  always @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // combinational read so a replay may be followed at once by a read
  assign rdata = mem[raddr];
endmodule

// >>> verilog/cfx_fifo_top.v
// cascadable 9-bit clocked fifo with flags, parity, replay and ahb regs
`timescale 1ns/1ps
`include "cfx_defs.vh"
// Notes on behaviour
// RQ1 - stores 9-bit words, depth 512, 2048 or 4096 by build variant
// RQ2 - write clock rising edge with write enable low captures the word
// RQ3 - a new word is accepted on every write clock edge, no gaps
// RQ4 - one word delivered per read clock edge while read enable is low
// RQ5 - works with common or fully independent read and write clocks
// RQ6 - chain: token out to next token in, last back to first
// RQ7 - standalone use holds the chain token input low
// RQ8 - replay low returns read position to start outside chain mode
// RQ9 - both enables stay high during replay; then reads fetch again
// RQ10 - three status outputs decode six fill states
// RQ11 - near-limit flag shares the token out pin, valid standalone only
// RQ12 - in chain mode that pin hands the token to the next device
// RQ13 - empty and almost-empty change only on read clock edges
// RQ14 - half, almost-full and full change only on write clock edges
// RQ15 - each flag is registered and holds for a whole clock cycle
// RQ16 - programmable near-limit threshold and parity generate or check
// RQ17 - write taken only when not full; bit 8 ignored when generating
// RQ18 - master reset empties; entry restores no parity, threshold 16
// RQ19 - in master reset write edge programs, read edge shows program reg
// RQ20 - output bit 8 is data, generated parity, or parity error flag
// RQ21 - pointers cross between clock sides in gray code, two stages
module cfx_fifo_top (
  input wire MCLK, // system clock
  input wire ARST_N, // asynchronous reset, active low
  input wire CE, // clock enable, freezes all state when low
  input wire HSEL, // ahb slave select
  input wire [31:0] HADDR, // ahb address
  input wire [1:0] HTRANS, // ahb transfer type
  input wire HWRITE, // ahb write
  input wire [2:0] HSIZE, // ahb size, words only
  input wire [31:0] HWDATA, // ahb write data
  input wire HREADY, // ahb bus ready
  output reg [31:0] HRDATA, // ahb read data
  output reg HREADYOUT, // ahb slave ready
  output reg HRESP, // ahb response, always okay
  input wire WR_CLK, // write port clock, sampled
  input wire RD_CLK, // read port clock, sampled
  input wire WR_EN_N, // write enable, active low
  input wire RD_EN_N, // read enable, active low
  input wire [8:0] D, // write data
  output reg [8:0] Q, // read data, bit 8 per parity mode
  input wire MASTER_RST_N, // master reset and programming, active low
  input wire REPLAY_N, // replay, or first-in-chain when cascaded
  input wire CHAIN_TOKEN_IN, // chain token input, active low
  output reg EMPTY_FULL_N, // low when empty or full
  output reg HALF_LEVEL_FLAG_N, // low when more than half full
  output reg LIMIT_OR_TOKEN_N // near-limit flag or chain token out
);
  reg wr_clk_d_r;
  reg rd_clk_d_r;
  reg mr_d_r;
  reg [`CFX_PW-1:0] wp_r;
  reg [`CFX_PW-1:0] rp_r;
  reg [`CFX_PW-1:0] wp_g_r;
  reg [`CFX_PW-1:0] rp_g_r;
  reg [8:0] prog_r;
  reg ctrl_casc_r;
  reg full_r;
  reg hf_r;
  reg af_r;
  reg empty_r;
  reg ae_r;
  reg wtok_r;
  reg rtok_r;
  reg w_pend_r;
  reg r_pend_r;
  reg [1:0] tx_cnt_r;
  reg [1:0] xi_cnt_r;
  reg bus_wr_r;
  reg [`CFX_ADDR_W-1:0] bus_addr_r;
  reg [31:0] rd_mux;
  wire [`CFX_PW-1:0] rp_sync_g;
  wire [`CFX_PW-1:0] wp_sync_g;
  wire [8:0] ram_q;

  function [`CFX_PW-1:0] bin2gray;
    input [`CFX_PW-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [`CFX_PW-1:0] gray2bin;
    input [`CFX_PW-1:0] g;
    integer i;
    begin
      gray2bin[`CFX_PW-1] = g[`CFX_PW-1];
      for (i = `CFX_PW - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  wire mr_act = ~MASTER_RST_N;
  wire mr_fall = mr_act & mr_d_r;
  // port clocks arrive as synchronous levels; their rising edges are events
  wire wr_rise = WR_CLK & ~wr_clk_d_r; // RQ5
  wire rd_rise = RD_CLK & ~rd_clk_d_r; // RQ5
  wire casc = ctrl_casc_r;
  wire par_en = prog_r[`CFX_CFG_PEN];
  wire par_gen = par_en & ~prog_r[`CFX_CFG_PCHK];
  wire par_chk = par_en & prog_r[`CFX_CFG_PCHK];
  wire [`CFX_PW-1:0] thr = {{(`CFX_PW-`CFX_THR_W){1'b0}},
                            prog_r[`CFX_THR_MSB:0]}; // RQ16

  // write side fill view, using the synchronised read pointer
  wire [`CFX_PW-1:0] rp_w = gray2bin(rp_sync_g); // RQ21
  wire [`CFX_PW-1:0] wcnt = wp_r - rp_w;
  wire w_ok = wr_rise & ~WR_EN_N & ~mr_act & (wcnt != `CFX_DEPTH) &
              (~casc | wtok_r); // RQ17
  wire [`CFX_PW-1:0] wcnt_nxt = wcnt + {{(`CFX_PW-1){1'b0}}, w_ok};
  wire [8:0] wword = par_gen ? {^D[7:0], D[7:0]} : D; // RQ17

  // read side fill view, using the synchronised write pointer
  wire [`CFX_PW-1:0] wp_s = gray2bin(wp_sync_g); // RQ21
  wire [`CFX_PW-1:0] rcnt = wp_s - rp_r;
  wire r_ok = rd_rise & ~RD_EN_N & ~mr_act & (rcnt != `CFX_ZERO) &
              (~casc | rtok_r); // RQ4
  wire [`CFX_PW-1:0] rcnt_nxt = rcnt - {{(`CFX_PW-1){1'b0}}, r_ok};
  // replay is ignored in chain mode since the pin names the first device
  wire replay = ~casc & ~REPLAY_N & ~mr_act; // RQ8

  // token handoffs: write token when this device fills, read token
  // when it drains after its write token has moved on
  wire w_pass = w_ok & casc & (wcnt_nxt == `CFX_DEPTH); // RQ12
  wire r_pass = r_ok & casc & ~wtok_r & (rcnt_nxt == `CFX_ZERO); // RQ12
  wire tx_load = (tx_cnt_r == `CFX_TX_IDLE) & (w_pend_r | r_pend_r);
  wire xi_end = casc & CHAIN_TOKEN_IN & (xi_cnt_r != `CFX_TX_IDLE);

  wire bus_req = HSEL & HTRANS[1] & HREADY;
  wire bus_wr_ctrl = bus_wr_r & (bus_addr_r == `CFX_A_CTRL);
  wire bus_wr_prog = bus_wr_r & (bus_addr_r == `CFX_A_PROG);

  cfx_ram u_ram (
    .clk(MCLK),
    .ce(CE),
    .we(w_ok), // RQ2
    .waddr(wp_r[`CFX_AW-1:0]),
    .wdata(wword),
    .raddr(rp_r[`CFX_AW-1:0]),
    .rdata(ram_q)
  ); // RQ1

  cfx_gray_sync u_rp_sync (
    .clk(MCLK),
    .arst_n(ARST_N),
    .ce(CE),
    .din(rp_g_r),
    .dout(rp_sync_g)
  ); // RQ21

  cfx_gray_sync u_wp_sync (
    .clk(MCLK),
    .arst_n(ARST_N),
    .ce(CE),
    .din(wp_g_r),
    .dout(wp_sync_g)
  ); // RQ21

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_clk_d_r <= 1'b0;
      rd_clk_d_r <= 1'b0;
      mr_d_r <= 1'b1; // idle level of the pin, so no false fall
    end else if (CE) begin
      wr_clk_d_r <= WR_CLK;
      rd_clk_d_r <= RD_CLK;
      mr_d_r <= MASTER_RST_N;
    end
  end

  // write pointer and write-clock flags
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wp_r <= `CFX_ZERO;
      wp_g_r <= `CFX_ZERO;
      full_r <= 1'b0;
      hf_r <= 1'b0;
      af_r <= 1'b0;
    end else if (CE) begin
      if (mr_act) begin
        wp_r <= `CFX_ZERO; // RQ18
        wp_g_r <= `CFX_ZERO;
        full_r <= 1'b0;
        hf_r <= 1'b0;
        af_r <= 1'b0;
      end else begin
        if (w_ok) begin
          wp_r <= wp_r + {{(`CFX_PW-1){1'b0}}, 1'b1}; // RQ3
          wp_g_r <= bin2gray(wp_r + {{(`CFX_PW-1){1'b0}}, 1'b1}); // RQ21
        end
        if (wr_rise) begin
          full_r <= (wcnt_nxt == `CFX_DEPTH); // RQ14
          hf_r <= (wcnt_nxt > `CFX_HALF); // RQ14
          af_r <= (wcnt_nxt >= (`CFX_DEPTH - thr)); // RQ14
        end
      end
    end
  end

  // read pointer, read-clock flags and the output word
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rp_r <= `CFX_ZERO;
      rp_g_r <= `CFX_ZERO;
      empty_r <= 1'b1;
      ae_r <= 1'b1;
      Q <= 9'h000;
    end else if (CE) begin
      if (mr_act) begin
        rp_r <= `CFX_ZERO; // RQ18
        rp_g_r <= `CFX_ZERO;
        empty_r <= 1'b1;
        ae_r <= 1'b1;
        if (rd_rise && !RD_EN_N) begin
          Q <= prog_r; // RQ19
        end
      end else begin
        if (replay) begin
          rp_r <= `CFX_ZERO; // RQ8
          rp_g_r <= `CFX_ZERO;
        end else if (r_ok) begin
          rp_r <= rp_r + {{(`CFX_PW-1){1'b0}}, 1'b1}; // RQ4
          rp_g_r <= bin2gray(rp_r + {{(`CFX_PW-1){1'b0}}, 1'b1}); // RQ21
        end
        if (r_ok) begin
          Q <= par_chk ? {^ram_q, ram_q[7:0]} : ram_q; // RQ20
        end
        if (rd_rise) begin
          empty_r <= (rcnt_nxt == `CFX_ZERO); // RQ13
          ae_r <= (rcnt_nxt <= thr); // RQ13
        end
      end
    end
  end

  // programming register: a write edge in master reset wins over the
  // default load so a program word on the entry edge is kept
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prog_r <= `CFX_CFG_DEF;
    end else if (CE) begin
      if (mr_act && wr_rise && !WR_EN_N) begin
        prog_r <= D; // RQ19
      end else if (mr_fall) begin
        prog_r <= `CFX_CFG_DEF; // RQ18
      end else if (bus_wr_prog) begin
        prog_r <= HWDATA[8:0]; // RQ16
      end
    end
  end

  // chain tokens: first-in-chain is read from the shared pin in reset
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wtok_r <= 1'b0;
      rtok_r <= 1'b0;
      xi_cnt_r <= `CFX_TX_IDLE;
    end else if (CE) begin
      if (mr_act) begin
        wtok_r <= ~REPLAY_N;
        rtok_r <= ~REPLAY_N;
        xi_cnt_r <= `CFX_TX_IDLE;
      end else begin
        if (w_pass) begin
          wtok_r <= 1'b0; // RQ12
        end else if (xi_end && xi_cnt_r == `CFX_XI_WR) begin
          wtok_r <= 1'b1; // RQ6
        end
        if (r_pass) begin
          rtok_r <= 1'b0; // RQ12
        end else if (xi_end && xi_cnt_r != `CFX_XI_WR) begin
          rtok_r <= 1'b1; // RQ6
        end
        // standalone holds the input low, so it is counted only in chain
        if (!casc || CHAIN_TOKEN_IN) begin
          xi_cnt_r <= `CFX_TX_IDLE; // RQ7
        end else if (xi_cnt_r != `CFX_XI_MAX) begin
          xi_cnt_r <= xi_cnt_r + 2'h1;
        end
      end
    end
  end

  // token pulses are queued so that two handoffs never merge
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_pend_r <= 1'b0;
      r_pend_r <= 1'b0;
      tx_cnt_r <= `CFX_TX_IDLE;
    end else if (CE) begin
      if (mr_act) begin
        w_pend_r <= 1'b0;
        r_pend_r <= 1'b0;
        tx_cnt_r <= `CFX_TX_IDLE;
      end else begin
        if (w_pass) begin
          w_pend_r <= 1'b1;
        end else if (tx_load && w_pend_r) begin
          w_pend_r <= 1'b0;
        end
        if (r_pass) begin
          r_pend_r <= 1'b1;
        end else if (tx_load && !w_pend_r) begin
          r_pend_r <= 1'b0;
        end
        if (tx_cnt_r != `CFX_TX_IDLE) begin
          tx_cnt_r <= tx_cnt_r - 2'h1;
        end else if (w_pend_r) begin
          tx_cnt_r <= `CFX_TX_WR; // RQ12
        end else if (r_pend_r) begin
          tx_cnt_r <= `CFX_TX_RD; // RQ12
        end
      end
    end
  end

  // status pins, each from its own flop
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EMPTY_FULL_N <= 1'b0;
      HALF_LEVEL_FLAG_N <= 1'b1;
      LIMIT_OR_TOKEN_N <= 1'b0;
    end else if (CE) begin
      EMPTY_FULL_N <= ~(empty_r | full_r); // RQ10
      HALF_LEVEL_FLAG_N <= ~hf_r; // RQ10
      if (casc) begin
        LIMIT_OR_TOKEN_N <= ~(tx_cnt_r >= `CFX_TX_LOW); // RQ12
      end else begin
        LIMIT_OR_TOKEN_N <= ~(ae_r | af_r); // RQ11
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    if (HADDR[`CFX_ADDR_W-1:0] == `CFX_A_CTRL) begin
      rd_mux[`CFX_CTRL_CASC] = ctrl_casc_r;
    end else if (HADDR[`CFX_ADDR_W-1:0] == `CFX_A_PROG) begin
      rd_mux[8:0] = prog_r;
    end else if (HADDR[`CFX_ADDR_W-1:0] == `CFX_A_STAT) begin
      rd_mux[7:0] = {casc, rtok_r, wtok_r, full_r, af_r, hf_r, ae_r,
                     empty_r}; // RQ15
      rd_mux[`CFX_ST_CNT_LSB+`CFX_PW-1:`CFX_ST_CNT_LSB] = wp_r - rp_r;
    end
  end

  // ahb-lite slave, zero wait states; unmapped reads give zero
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_wr_r <= 1'b0;
      bus_addr_r <= `CFX_A_CTRL;
      ctrl_casc_r <= 1'b0;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else if (CE) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY) begin
        bus_wr_r <= bus_req & HWRITE;
        bus_addr_r <= HADDR[`CFX_ADDR_W-1:0];
        if (bus_req && !HWRITE) begin
          HRDATA <= rd_mux;
        end
      end
      if (bus_wr_ctrl) begin
        ctrl_casc_r <= HWDATA[`CFX_CTRL_CASC];
      end
    end
  end
endmodule

// >>> verif/cfx_fifo_top_asserts.sv
// concurrent checks on the fifo top ports
`timescale 1ns/1ps
module cfx_fifo_top_asserts (
  input wire MCLK, // system clock
  input wire ARST_N, // async reset
  input wire WR_CLK, // write port clock
  input wire RD_CLK, // read port clock
  input wire MASTER_RST_N, // master reset
  input wire [8:0] Q, // read data
  input wire HREADYOUT, // bus ready
  input wire HRESP, // bus response
  input wire EMPTY_FULL_N, // empty or full
  input wire HALF_LEVEL_FLAG_N, // over half
  input wire LIMIT_OR_TOKEN_N, // near limit
  input wire CHAIN_TOKEN_IN // chain token in, held low standalone
);
  reg wr_d_r;
  reg rd_d_r;
  reg [1:0] wr_age_r;
  reg [1:0] rd_age_r;
  reg [1:0] mr_age_r;
  wire wr_rise = WR_CLK & ~wr_d_r;
  wire rd_rise = RD_CLK & ~rd_d_r;
  wire wr_new = wr_age_r < 2'h3;
  wire rd_new = rd_age_r < 2'h3;
  wire mr_new = mr_age_r < 2'h3;
  // ages saturate at 3: a pin lags its port edge by one more cycle
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_d_r <= 1'h0;
      rd_d_r <= 1'h0;
      wr_age_r <= 2'h0;
      rd_age_r <= 2'h0;
      mr_age_r <= 2'h0;
    end else begin
      wr_d_r <= WR_CLK;
      rd_d_r <= RD_CLK;
      wr_age_r <= wr_rise ? 2'h0 : wr_age_r + {1'h0, wr_new};
      rd_age_r <= rd_rise ? 2'h0 : rd_age_r + {1'h0, rd_new};
      mr_age_r <= !MASTER_RST_N ? 2'h0 : mr_age_r + {1'h0, mr_new};
    end
  end
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  sequence mr_entry;
    $fell(MASTER_RST_N) ##1 !MASTER_RST_N [*2];
  endsequence
  a_mr_empties:
    assert property (mr_entry |=> !EMPTY_FULL_N && HALF_LEVEL_FLAG_N)
    else $error("flags not empty in master reset");
  // chained, the shared pin carries the token, so only standalone decodes
  a_decode_legal:
    assert property (!CHAIN_TOKEN_IN && !EMPTY_FULL_N |-> !LIMIT_OR_TOKEN_N)
    else $error("illegal status pin combination");
  a_bus_okay:
    assert property ($past(ARST_N) |-> HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  a_q_on_read:
    assert property ($changed(Q) |-> $past(rd_rise))
    else $error("read data moved without read edge");
  a_ef_cause:
    assert property ($changed(EMPTY_FULL_N) |-> rd_new || wr_new || mr_new)
    else $error("empty or full pin moved without port edge");
  a_hf_cause:
    assert property ($changed(HALF_LEVEL_FLAG_N) |-> wr_new || mr_new)
    else $error("half pin moved without write edge");
  a_limit_cause:
    assert property ($changed(LIMIT_OR_TOKEN_N) |-> rd_new || wr_new || mr_new)
    else $error("limit pin moved without port edge");
  a_hf_hold:
    assert property ($changed(HALF_LEVEL_FLAG_N) |=> $stable(HALF_LEVEL_FLAG_N))
    else $error("half pin held under one cycle");
endmodule

// >>> verif/cfx_port_model.sv
// writer and reader logic on the far side of the fifo ports
`timescale 1ns/1ps
module cfx_port_model (
  input wire mclk, // system clock
  input wire [8:0] q, // fifo read data
  output reg wr_clk, // write port clock
  output reg rd_clk, // read port clock
  output reg wr_en_n, // write enable
  output reg rd_en_n, // read enable
  output reg [8:0] d // write data
);
  // port clocks stand still between transfers, enables idle high
  initial begin
    wr_clk = 1'h0;
    rd_clk = 1'h0;
    wr_en_n = 1'h1;
    rd_en_n = 1'h1;
    d = 9'h000;
  end
  // gap adds low cycles for a slow writer
  task push(input [8:0] w, input integer gap);
    begin
      @(posedge mclk);
      wr_clk <= 1'h1;
      wr_en_n <= 1'h0;
      d <= w;
      @(posedge mclk);
      wr_clk <= 1'h0;
      wr_en_n <= 1'h1;
      d <= ~w;
      repeat (gap) @(posedge mclk);
    end
  endtask
  // en low gives a bare clock edge that only refreshes flags
  task pop(output [8:0] v, input en);
    begin
      @(posedge mclk);
      rd_clk <= 1'h1;
      rd_en_n <= ~en;
      @(posedge mclk);
      rd_clk <= 1'h0;
      rd_en_n <= 1'h1;
      #1 v = q;
    end
  endtask
endmodule

// >>> verif/cfx_fifo_top_tb.sv
// self-checking bench for the cascadable clocked fifo
`timescale 1ns/1ps
module cfx_fifo_top_tb;
  reg MCLK = 1'h0;
  reg ARST_N = 1'h0;
  reg MASTER_RST_N = 1'h1;
  reg REPLAY_N = 1'h1;
  reg [31:0] HADDR = 32'h0000_0000;
  reg [1:0] HTRANS = 2'h0;
  reg HWRITE = 1'h0;
  reg [31:0] HWDATA = 32'h0000_0000;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, WR_CLK, RD_CLK, WR_EN_N, RD_EN_N;
  wire EMPTY_FULL_N, HALF_LEVEL_FLAG_N, LIMIT_OR_TOKEN_N;
  wire [8:0] D, Q;
  reg chain_loop = 1'h0;
  wire CHAIN_TOKEN_IN;
  // standalone holds the token input low; chained, one device rings itself
  assign CHAIN_TOKEN_IN = chain_loop & LIMIT_OR_TOKEN_N;
  integer errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer i;
  reg [31:0] rv;
  reg [8:0] qv;
  reg [7:0] w;
  always #20 MCLK = ~MCLK;
  cfx_fifo_top dut (.MCLK(MCLK), .ARST_N(ARST_N), .CE(1'h1), .HSEL(1'h1),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WR_CLK(WR_CLK), .RD_CLK(RD_CLK),
    .WR_EN_N(WR_EN_N), .RD_EN_N(RD_EN_N), .D(D), .Q(Q),
    .MASTER_RST_N(MASTER_RST_N), .REPLAY_N(REPLAY_N),
    .CHAIN_TOKEN_IN(CHAIN_TOKEN_IN),
    .EMPTY_FULL_N(EMPTY_FULL_N), .HALF_LEVEL_FLAG_N(HALF_LEVEL_FLAG_N),
    .LIMIT_OR_TOKEN_N(LIMIT_OR_TOKEN_N));
  cfx_port_model pm (.mclk(MCLK), .q(Q), .wr_clk(WR_CLK), .rd_clk(RD_CLK),
    .wr_en_n(WR_EN_N), .rd_en_n(RD_EN_N), .d(D));
  function [31:0] x9(input [8:0] v);
    x9 = {23'h0, v};
  endfunction
  function [7:0] pat(input integer k);
    pat = k[7:0] * 8'h35 + 8'h1c;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task ahb(input wr, input [31:0] a, input [31:0] wd);
    begin
      @(posedge MCLK);
      HADDR <= a;
      HTRANS <= 2'h2;
      HWRITE <= wr;
      @(posedge MCLK);
      while (HREADYOUT !== 1'h1) @(posedge MCLK);
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge MCLK);
      while (HREADYOUT !== 1'h1) @(posedge MCLK);
      rv = HRDATA;
    end
  endtask
  // ld low leaves the register to its master reset default
  task prog_mr(input [8:0] p, input ld);
    begin
      @(posedge MCLK);
      MASTER_RST_N <= 1'h0;
      repeat (3) @(posedge MCLK);
      if (ld)
        pm.push(p, 0);
      pm.pop(qv, 1'h1);
      chk(x9(qv), x9(p));
      @(posedge MCLK);
      MASTER_RST_N <= 1'h1;
      repeat (4) @(posedge MCLK);
      ahb(1'h0, 32'h0000_0004, 32'h0);
      chk(rv, x9(p));
    end
  endtask
  always @(posedge MCLK) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge MCLK);
    ARST_N <= 1'h1;
    repeat (2) @(posedge MCLK);
    ahb(1'h0, 32'h0000_0004, 32'h0);
    chk(rv, 32'h0000_0010);
    ahb(1'h1, 32'h0000_000c, 32'hffff_ffff);
    ahb(1'h0, 32'h0000_000c, 32'h0);
    chk(rv, 32'h0000_0000);
    // generate mode, threshold 5; bit 8 driven wrong on purpose
    prog_mr(9'h105, 1'h1);
    for (i = 0; i < 4; i = i + 1)
      pm.push({~(^pat(i)), pat(i)}, 3);
    repeat (4) @(posedge MCLK);
    for (i = 0; i < 5; i = i + 1) begin
      pm.pop(qv, 1'h1);
      chk(x9(qv), x9({^pat(i % 4 + i / 4 * 3), pat(i % 4 + i / 4 * 3)}));
    end
    @(posedge MCLK);
    REPLAY_N <= 1'h0;
    repeat (2) @(posedge MCLK);
    REPLAY_N <= 1'h1;
    pm.pop(qv, 1'h0);
    for (i = 0; i < 2; i = i + 1) begin
      pm.pop(qv, 1'h1);
      chk(x9(qv), x9({^pat(i), pat(i)}));
    end
    prog_mr(9'h180, 1'h1);
    w = 8'h6b;
    pm.push({^w, w}, 0);
    pm.push({~(^w), w}, 0);
    repeat (4) @(posedge MCLK);
    pm.pop(qv, 1'h1);
    chk(x9(qv), x9({1'h0, w}));
    pm.pop(qv, 1'h1);
    chk(x9(qv), x9({1'h1, w}));
    prog_mr(9'h010, 1'h0);
    ahb(1'h0, 32'h0000_0008, 32'h0);
    chk(rv, 32'h0000_0003);
    for (i = 0; i < 4096; i = i + 1) begin
      pm.push(i[8:0], 0);
      if (i == 2047 || i == 2048) begin
        repeat (2) @(posedge MCLK);
        chk({31'h0, HALF_LEVEL_FLAG_N}, {31'h0, i == 2047});
      end
    end
    pm.push(9'h0aa, 0);
    pm.pop(qv, 1'h0);
    repeat (2) @(posedge MCLK);
    ahb(1'h0, 32'h0000_0008, 32'h0);
    chk(rv, 32'h1000_001c);
    chk({29'h0, EMPTY_FULL_N, HALF_LEVEL_FLAG_N, LIMIT_OR_TOKEN_N}, 0);
    for (i = 0; i < 4097; i = i + 1) begin
      pm.pop(qv, 1'h1);
      chk(x9(qv), x9(i < 4096 ? i[8:0] : 9'h1ff));
    end
    chk({31'h0, EMPTY_FULL_N}, 32'h0);
    // chain mode is set while master reset holds the device empty
    @(posedge MCLK);
    chain_loop <= 1'h1;
    REPLAY_N <= 1'h0;
    MASTER_RST_N <= 1'h0;
    ahb(1'h1, 32'h0000_0000, 32'h0000_0001);
    repeat (2) @(posedge MCLK);
    MASTER_RST_N <= 1'h1;
    REPLAY_N <= 1'h1;
    pm.push(9'h055, 0);
    repeat (4) @(posedge MCLK);
    ahb(1'h0, 32'h0000_0008, 32'h0);
    chk(rv, 32'h0001_00e3);
    chk({31'h0, LIMIT_OR_TOKEN_N}, 32'h0000_0001);
    pm.pop(qv, 1'h1);
    chk(x9(qv), x9(9'h055));
    // not first in chain: no token, so the write is dropped
    @(posedge MCLK);
    MASTER_RST_N <= 1'h0;
    repeat (3) @(posedge MCLK);
    MASTER_RST_N <= 1'h1;
    pm.push(9'h0aa, 0);
    repeat (4) @(posedge MCLK);
    ahb(1'h0, 32'h0000_0008, 32'h0);
    chk(rv, 32'h0000_0083);
    tally_and_finish;
  end
endmodule
bind cfx_fifo_top cfx_fifo_top_asserts chk_i (.MCLK(MCLK), .ARST_N(ARST_N),
  .WR_CLK(WR_CLK), .RD_CLK(RD_CLK), .MASTER_RST_N(MASTER_RST_N), .Q(Q),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EMPTY_FULL_N(EMPTY_FULL_N),
  .HALF_LEVEL_FLAG_N(HALF_LEVEL_FLAG_N),
  .LIMIT_OR_TOKEN_N(LIMIT_OR_TOKEN_N), .CHAIN_TOKEN_IN(CHAIN_TOKEN_IN));
